/* File: pdocc_pkg.sv */
// Register map, field layout, reset values and types of the PLL/DLL output clock control
// Function
// - Eight 45-degree phases, chosen per output
// - Unused output held constant low
// - Per-output integer divider, ratio 1 to 127
// - Per-output release delay, 0 to 7
// - Fractional feedback divider with 24-bit fraction
// - Glitch-free stop/start from register or fabric
// - Settings changed while stopped apply on restart
// - DLL measures taps for 90-degree shift
// - Tap value shared, per-lane update control
// - Injection mode: x1 output, divided shifted output
package pdocc_pkg;
  localparam int NUM_OUT = 4;
  localparam int NUM_LANE = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FB_INT = 8'h04;
  localparam logic [7:0] OFS_FB_FRAC = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_OUTCFG = 8'h10;
  localparam logic [7:0] OFS_OUTCFG_LAST = 8'h1c;
  localparam logic [7:0] OFS_LANE_UPD = 8'h20;
  // Control register fields
  localparam int CTRL_STOP_LSB = 0;
  localparam int CTRL_FABEN_LSB = 4;
  localparam int CTRL_DLL_MODE_BIT = 8;
  localparam int CTRL_DLL_DIV_LSB = 9;
  localparam int CTRL_DLL_SHIFT_LSB = 12;
  // Output configuration fields
  localparam int CFG_DIV_LSB = 0;
  localparam int CFG_PHASE_LSB = 8;
  localparam int CFG_DELAY_LSB = 12;
  localparam int CFG_UNUSED_BIT = 16;
  // Status fields
  localparam int STAT_RUN_LSB = 0;
  localparam int STAT_PEND_LSB = 4;
  localparam int STAT_TAP_LSB = 8;
  localparam int STAT_FBDIV_LSB = 16;
  // Reset values
  localparam logic [3:0] CTRL_STOP_RST = 4'hf;
  localparam logic [6:0] DIV_RST = 7'h01;
  localparam logic [7:0] FB_INT_RST = 8'h10;
  localparam logic [23:0] FB_FRAC_RST = 24'h00_0000;
  // DLL divided-output ratio codes
  localparam logic [1:0] DLL_DIV_X1 = 2'h0;
  localparam logic [1:0] DLL_DIV_X2 = 2'h1;
  localparam logic [1:0] DLL_DIV_X4 = 2'h2;
  // Per-output divider sequence
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ALIGN = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN = 3'b011
  } pdocc_div_st_e;
endpackage

/* File: pdocc_div.sv */
// One glitch-free output divider with phase alignment and release delay
`timescale 1ns/100ps
`default_nettype none
module pdocc_div
  import pdocc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run_req,
  input wire logic [2:0] vco_phase,
  input wire logic [6:0] div_ratio,
  input wire logic [2:0] phase_sel,
  input wire logic [2:0] rel_delay,
  input wire logic unused,
  // Output
  output logic clk_out,
  output logic running
);
  pdocc_div_st_e state;
  logic [6:0] ratio_q;
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic [6:0] half;
  logic [2:0] phase_q;
  logic [2:0] delay_q;
  logic [2:0] dly;

  // Period counter wraps at ratio; high for the first half
  assign next_cnt = (cnt == ratio_q - 7'h01) ? 7'h00 : cnt + 7'h01;
  assign half = 7'((8'(ratio_q) + 8'h01) >> 1);

  // Sequence; settings are snapshot only when leaving idle, so a running output never sees a change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      running <= 1'b0;
      ratio_q <= DIV_RST;
      phase_q <= 3'h0;
      delay_q <= 3'h0;
      dly <= 3'h0;
      cnt <= 7'h00;
      clk_out <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          clk_out <= 1'b0;
          if (run_req && !unused) begin
            ratio_q <= (div_ratio == 7'h00) ? 7'h01 : div_ratio;
            phase_q <= phase_sel;
            delay_q <= rel_delay;
            running <= 1'b1;
            state <= ST_ALIGN;
          end
        end
        ST_ALIGN: begin
          if (!run_req) begin
            running <= 1'b0;
            state <= ST_IDLE;
          end else if (vco_phase == phase_q) begin
            dly <= delay_q;
            state <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (!run_req) begin
            running <= 1'b0;
            state <= ST_IDLE;
          end else if (dly == 3'h0) begin
            cnt <= 7'h00;
            clk_out <= 1'b1;
            state <= ST_RUN;
          end else begin
            dly <= dly - 3'h1;
          end
        end
        ST_RUN: begin
          // Stop only at a period boundary so no runt pulse leaves
          if (!run_req && next_cnt == 7'h00) begin
            clk_out <= 1'b0;
            cnt <= 7'h00;
            running <= 1'b0;
            state <= ST_IDLE;
          end else begin
            cnt <= next_cnt;
            clk_out <= (next_cnt < half);
          end
        end
        default: begin
          clk_out <= 1'b0;
          running <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Checks on the output sequence
  idle_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_IDLE) |-> !clk_out)
    else $error("output not low while stopped");
  unused_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_IDLE && unused) |=> (state == ST_IDLE))
    else $error("unused output started");
  edge_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(clk_out) |-> (state == ST_RUN && cnt == 7'h00))
    else $error("output rose inside a period");
  cnt_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_RUN) |-> (cnt < ratio_q && ratio_q != 7'h00))
    else $error("divider count out of range");
  phase_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(state) == ST_ALIGN && state == ST_DELAY) |-> ($past(vco_phase) == phase_q))
    else $error("release not on selected phase");
  release_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_ALIGN && run_req && vco_phase == phase_q && delay_q == 3'h6)
      |-> (run_req [*8] |=> (state == ST_RUN)))
    else $error("release delay of six not kept");
  cfg_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state != ST_IDLE) |=> ($stable(ratio_q) && $stable(phase_q) && $stable(delay_q)))
    else $error("settings changed while running");
endmodule
`default_nettype wire

/* File: pdocc_top.sv */
// PLL output clock control and DLL tap/injection logic behind an APB slave
`timescale 1ns/100ps
`default_nettype none
module pdocc_top
  import pdocc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fabric and pin inputs
  input wire logic [3:0] fab_stop,
  input wire logic ref_clk_in,
  input wire logic dll_clk_in,
  // PLL outputs
  output logic [3:0] pll_clk_out,
  output logic [8:0] fb_div_now,
  // DLL outputs
  output logic [3:0][7:0] lane_tap,
  output logic dll_out_x1,
  output logic dll_out_div
);
  localparam int NSYNC = NUM_OUT + 2;

  // Control state
  logic [3:0] ctrl_stop;
  logic [3:0] ctrl_faben;
  logic dll_mode;
  logic [1:0] dll_div;
  logic [1:0] dll_shift;
  logic [7:0] fb_int;
  logic [23:0] fb_frac;
  logic [6:0] cfg_div [NUM_OUT];
  logic [2:0] cfg_phase [NUM_OUT];
  logic [2:0] cfg_delay [NUM_OUT];
  logic [NUM_OUT-1:0] cfg_unused;
  logic [NUM_OUT-1:0] pend;
  logic [NUM_OUT-1:0] running;
  logic [NUM_OUT-1:0] run_req;

  // Synchronised pins
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] pin_f;
  logic [3:0] fab_f;
  logic ref_f;
  logic dllc_f;
  logic ref_prev;
  logic dllc_prev;
  logic ref_rise;
  logic dll_rise;

  // Shared phase, fraction and DLL state
  logic [2:0] vco_phase;
  logic [23:0] frac_acc;
  logic [24:0] frac_sum;
  logic [7:0] per_cnt;
  logic [7:0] tap_meas;
  logic [1:0] inj_cnt;
  logic inj_src;
  logic [3:0] inj_shr;

  // Bus decode
  logic setup_ph;
  logic wr_en;
  logic addr_ok;
  logic [31:0] rd_val;
  logic [1:0] cfg_idx;

  // Pin inputs; a change is taken once the second and third stages agree
  assign pin_raw = {dll_clk_in, ref_clk_in, fab_stop};
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          pin_f[g] <= 1'b0;
        end else begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            pin_f[g] <= sync3[g];
          end
        end
      end
    end
  endgenerate

  assign fab_f = pin_f[NUM_OUT-1:0];
  assign ref_f = pin_f[NUM_OUT];
  assign dllc_f = pin_f[NUM_OUT+1];
  assign ref_rise = ref_f && !ref_prev;
  assign dll_rise = dllc_f && !dllc_prev;

  // Edge history of the filtered clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev <= 1'b0;
      dllc_prev <= 1'b0;
    end else begin
      ref_prev <= ref_f;
      dllc_prev <= dllc_f;
    end
  end

  // APB phases; zero-wait slave, answer lands in the access phase
  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_FB_INT) || (paddr == OFS_FB_FRAC) ||
                   (paddr == OFS_STATUS) || (paddr == OFS_LANE_UPD) ||
                   (paddr >= OFS_OUTCFG && paddr <= OFS_OUTCFG_LAST && paddr[1:0] == 2'h0);
  assign cfg_idx = paddr[3:2];

  // Read data assembly; reserved bits read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (paddr == OFS_CTRL) begin
      rd_val[CTRL_STOP_LSB +: 4] = ctrl_stop;
      rd_val[CTRL_FABEN_LSB +: 4] = ctrl_faben;
      rd_val[CTRL_DLL_MODE_BIT] = dll_mode;
      rd_val[CTRL_DLL_DIV_LSB +: 2] = dll_div;
      rd_val[CTRL_DLL_SHIFT_LSB +: 2] = dll_shift;
    end else if (paddr == OFS_FB_INT) begin
      rd_val[7:0] = fb_int;
    end else if (paddr == OFS_FB_FRAC) begin
      rd_val[23:0] = fb_frac;
    end else if (paddr == OFS_STATUS) begin
      rd_val[STAT_RUN_LSB +: 4] = running;
      rd_val[STAT_PEND_LSB +: 4] = pend;
      rd_val[STAT_TAP_LSB +: 8] = tap_meas;
      rd_val[STAT_FBDIV_LSB +: 9] = fb_div_now;
    end else if (paddr >= OFS_OUTCFG && paddr <= OFS_OUTCFG_LAST) begin
      rd_val[CFG_DIV_LSB +: 7] = cfg_div[cfg_idx];
      rd_val[CFG_PHASE_LSB +: 3] = cfg_phase[cfg_idx];
      rd_val[CFG_DELAY_LSB +: 3] = cfg_delay[cfg_idx];
      rd_val[CFG_UNUSED_BIT] = cfg_unused[cfg_idx];
    end
  end

  // Bus answer registers, captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !addr_ok;
      if (setup_ph) begin
        prdata <= (pwrite || !addr_ok) ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // Control register: stop bits, fabric enables, DLL mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_stop <= CTRL_STOP_RST;
      ctrl_faben <= 4'h0;
      dll_mode <= 1'b0;
      dll_div <= DLL_DIV_X1;
      dll_shift <= 2'h0;
    end else if (wr_en && paddr == OFS_CTRL) begin
      ctrl_stop <= pwdata[CTRL_STOP_LSB +: 4];
      ctrl_faben <= pwdata[CTRL_FABEN_LSB +: 4];
      dll_mode <= pwdata[CTRL_DLL_MODE_BIT];
      dll_div <= pwdata[CTRL_DLL_DIV_LSB +: 2];
      dll_shift <= pwdata[CTRL_DLL_SHIFT_LSB +: 2];
    end
  end

  // Feedback divider settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_int <= FB_INT_RST;
      fb_frac <= FB_FRAC_RST;
    end else if (wr_en && paddr == OFS_FB_INT) begin
      fb_int <= pwdata[7:0];
    end else if (wr_en && paddr == OFS_FB_FRAC) begin
      fb_frac <= pwdata[23:0];
    end
  end

  // Eight phases of one base clock feed every output alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vco_phase <= 3'h0;
    end else begin
      vco_phase <= vco_phase + 3'h1;
    end
  end

  // Fraction accumulator: carry picks N or N+1 on each reference edge
  assign frac_sum = {1'b0, frac_acc} + {1'b0, fb_frac};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frac_acc <= 24'h00_0000;
      fb_div_now <= {1'b0, FB_INT_RST};
    end else if (ref_rise) begin
      frac_acc <= frac_sum[23:0];
      fb_div_now <= {1'b0, fb_int} + {8'h00, frac_sum[24]};
    end
  end

  // Per-output configuration, pending flag and divider
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      logic sel;
      assign sel = wr_en && (paddr == OFS_OUTCFG + 8'(4 * g));
      // Stop from register, or from fabric where enabled
      assign run_req[g] = !(ctrl_stop[g] || (ctrl_faben[g] && fab_f[g]));

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_div[g] <= DIV_RST;
          cfg_phase[g] <= 3'h0;
          cfg_delay[g] <= 3'h0;
          cfg_unused[g] <= 1'b0;
        end else if (sel) begin
          cfg_div[g] <= pwdata[CFG_DIV_LSB +: 7];
          cfg_phase[g] <= pwdata[CFG_PHASE_LSB +: 3];
          cfg_delay[g] <= pwdata[CFG_DELAY_LSB +: 3];
          cfg_unused[g] <= pwdata[CFG_UNUSED_BIT];
        end
      end

      // Pending while running; a write while stopped is not flagged, the clear wins
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend[g] <= 1'b0;
        end else if (sel && running[g]) begin
          pend[g] <= 1'b1;
        end else if (!running[g]) begin
          pend[g] <= 1'b0;
        end
      end

      pdocc_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run_req(run_req[g]),
        .vco_phase(vco_phase),
        .div_ratio(cfg_div[g]),
        .phase_sel(cfg_phase[g]),
        .rel_delay(cfg_delay[g]),
        .unused(cfg_unused[g]),
        .clk_out(pll_clk_out[g]),
        .running(running[g])
      );
    end
  endgenerate

  // Period of the DLL input in taps; a quarter of it gives 90 degrees
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt <= 8'h00;
      tap_meas <= 8'h00;
    end else if (dll_rise) begin
      per_cnt <= 8'h01;
      if (!dll_mode) begin
        tap_meas <= {2'h0, per_cnt[7:2]};
      end
    end else if (per_cnt != 8'hff) begin
      per_cnt <= per_cnt + 8'h01; // Saturates on a slow or stalled input
    end
  end

  // Lane taps move only when that lane asks, so a lane mid-burst is left alone
  generate
    for (g = 0; g < NUM_LANE; g++) begin : g_lane
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lane_tap[g] <= 8'h00;
        end else if (wr_en && paddr == OFS_LANE_UPD && pwdata[g] && !dll_mode) begin
          lane_tap[g] <= tap_meas;
        end
      end
    end
  endgenerate

  // Injection mode: divide the input by counting its rising edges
  always_comb begin
    unique case (dll_div)
      DLL_DIV_X2: inj_src = inj_cnt[0];
      DLL_DIV_X4: inj_src = inj_cnt[1];
      default: inj_src = dllc_f;
    endcase
  end

  // Injection divider counter and phase shift line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inj_cnt <= 2'h0;
      inj_shr <= 4'h0;
    end else begin
      if (dll_rise) begin
        inj_cnt <= inj_cnt + 2'h1;
      end
      inj_shr <= {inj_shr[2:0], inj_src};
    end
  end

  // Injection outputs, held low in time reference mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dll_out_x1 <= 1'b0;
      dll_out_div <= 1'b0;
    end else begin
      dll_out_x1 <= dll_mode && dllc_f;
      dll_out_div <= dll_mode && inj_shr[dll_shift];
    end
  end

  // Checks at the top level
  bus_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph |=> (pready ##1 !pready))
    else $error("APB answer not in access phase");
  lane_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == OFS_LANE_UPD && pwdata[0] && !dll_mode && !pwdata[1])
      |=> (lane_tap[0] == $past(tap_meas) && $stable(lane_tap[1])))
    else $error("lane tap update wrong");
  inj_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!dll_mode ##1 !dll_mode) |-> (!dll_out_x1 && !dll_out_div))
    else $error("injection output active in tap mode");
  frac_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(ref_rise) && $stable(fb_int))
      |-> (fb_div_now == {1'b0, fb_int} || fb_div_now == {1'b0, fb_int} + 9'h001))
    else $error("feedback divisor outside N and N+1");
  pend_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pend[0] && running[0]) |=> (pend[0] || !$past(running[0])))
    else $error("pending change dropped while running");
endmodule
`default_nettype wire

/* File: pdocc_far_model.sv */
// Fabric side model: reference clock, DLL input clock and fabric stop pins
`timescale 1ns/100ps
`default_nettype none
module pdocc_far_model
  import pdocc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Settings from the bench
  input wire logic [7:0] ref_half,
  input wire logic [7:0] dll_half,
  input wire logic [3:0] stop_req,
  // Pins toward the block
  output logic ref_clk_in,
  output logic dll_clk_in,
  output logic [3:0] fab_stop
);
  logic [7:0] ref_cnt;
  logic [7:0] dll_cnt;
  // Free-running reference, half period in pclk cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt <= 8'h00;
      ref_clk_in <= 1'b0;
    end else if (ref_cnt >= ref_half - 8'h01) begin
      ref_cnt <= 8'h00;
      ref_clk_in <= ~ref_clk_in;
    end else begin
      ref_cnt <= ref_cnt + 8'h01;
    end
  end
  // DLL input clock; a new half period applies at once, to the half in progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dll_cnt <= 8'h00;
      dll_clk_in <= 1'b0;
    end else if (dll_cnt >= dll_half - 8'h01) begin
      dll_cnt <= 8'h00;
      dll_clk_in <= ~dll_clk_in;
    end else begin
      dll_cnt <= dll_cnt + 8'h01;
    end
  end
  // Fabric stop from a flop, as fabric logic would drive it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fab_stop <= 4'h0;
    end else begin
      fab_stop <= stop_req;
    end
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench of the PLL/DLL output clock control
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import pdocc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] fab_stop;
  logic ref_clk_in;
  logic dll_clk_in;
  logic [3:0] pll_clk_out;
  logic [8:0] fb_div_now;
  logic [3:0][7:0] lane_tap;
  logic dll_out_x1;
  logic dll_out_div;
  logic [7:0] ref_half = 8'h04;
  logic [7:0] dll_half = 8'h28;
  logic [3:0] stop_req = 4'h0;
  logic [31:0] rs = 32'h29b83075;
  logic [31:0] rd;
  logic er;
  logic [31:0] v;
  logic [7:0] ra[4] = '{OFS_CTRL, OFS_FB_INT, OFS_FB_FRAC, OFS_OUTCFG};
  logic [31:0] rv[4] = '{{28'h0, CTRL_STOP_RST}, {24'h0, FB_INT_RST}, {8'h0, FB_FRAC_RST}, {25'h0, DIV_RST}};
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int t[4];
  int p[4];
  int d[4];
  int a, b, pd, hw, r, d0, n1, no;

  // Clock and cycle count
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  pdocc_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fab_stop(fab_stop), .ref_clk_in(ref_clk_in), .dll_clk_in(dll_clk_in), .pll_clk_out(pll_clk_out),
    .fb_div_now(fb_div_now), .lane_tap(lane_tap), .dll_out_x1(dll_out_x1), .dll_out_div(dll_out_div));
  pdocc_far_model far (.pclk(pclk), .presetn(presetn), .ref_half(ref_half), .dll_half(dll_half),
    .stop_req(stop_req), .ref_clk_in(ref_clk_in), .dll_clk_in(dll_clk_in), .fab_stop(fab_stop));

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic sg(input int w);
    return (w < 4) ? pll_clk_out[w] : ((w == 4) ? dll_out_x1 : dll_out_div);
  endfunction
  function automatic int m8(input int x);
    return ((x % 8) + 8) % 8;
  endfunction
  function automatic logic [31:0] cfg(input int dv, input int ph, input int dl);
    return (32'(dl) << CFG_DELAY_LSB) | (32'(ph) << CFG_PHASE_LSB) | 32'(dv);
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One APB transfer; the slave answers when it will
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sampled just after the edge so the design's updates have landed
  task automatic rise(input int w, output int tm);
    int k = 0;
    do begin
      @(posedge pclk);
      #1;
      k++;
    end while (sg(w) !== 1'b0 && k < 3000);
    do begin
      @(posedge pclk);
      #1;
      k++;
    end while (sg(w) !== 1'b1 && k < 3000);
    chk(sg(w), 1'b1);
    tm = cyc;
  endtask
  task automatic per(input int w, output int pp, output int hh);
    int s0, s1;
    int k = 0;
    rise(w, s0);
    do begin
      @(posedge pclk);
      #1;
      k++;
    end while (sg(w) !== 1'b0 && k < 3000);
    hh = cyc - s0;
    rise(w, s1);
    pp = s1 - s0;
  endtask

  // Watchdog sized well above the expected run
  initial begin
    #2000000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then an unmapped place
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    chk(pll_clk_out, 4'h0);
    chk(fb_div_now, 9'h010);
    apb(1'b1, 8'h24, 32'hffffffff);
    chk(er, 1'b1);
    apb(1'b0, 8'h24, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    for (int i = 0; i < 3; i++) begin
      v = xs();
      apb(1'b1, OFS_FB_FRAC, v);
      apb(1'b0, OFS_FB_FRAC, 32'h0);
      chk(rd, {8'h0, v[23:0]});
    end
    // Half fraction: divisor alternates between N and N+1
    apb(1'b1, OFS_FB_INT, 32'h20);
    apb(1'b1, OFS_FB_FRAC, 32'h00800000);
    repeat (64) @(posedge pclk);
    n1 = 0;
    no = 0;
    repeat (256) begin
      @(posedge pclk);
      #1;
      if (fb_div_now === 9'h021) n1++;
      else if (fb_div_now !== 9'h020) no++;
    end
    chk(no, 0);
    chk(n1 >= 112 && n1 <= 144, 1'b1);
    // Same ratio everywhere, random phase and delay, corners on 0 and 3
    for (int i = 0; i < 4; i++) begin
      p[i] = xs() % 8;
      d[i] = xs() % 8;
    end
    p[0] = 0;
    d[0] = 0;
    p[3] = 7;
    d[3] = 7;
    d[1] = 6; // Reaches the delay-of-six check
    for (int i = 0; i < 4; i++) apb(1'b1, OFS_OUTCFG + 8'(4 * i), cfg(8, p[i], d[i]));
    apb(1'b1, OFS_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rise(i, t[i]);
      chk(m8(t[i] - t[0]), m8(p[i] + d[i] - p[0] - d[0]));
    end
    // Change while running stays pending
    apb(1'b1, OFS_OUTCFG, cfg(6, 1, 2));
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[STAT_PEND_LSB], 1'b1);
    chk(rd[STAT_RUN_LSB], 1'b1);
    per(0, pd, hw);
    chk(pd, 8);
    chk(hw, 4);
    apb(1'b1, OFS_CTRL, 32'hf);
    repeat (40) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[7:0], 8'h00);
    chk(pll_clk_out, 4'h0);
    // New settings while stopped unused output, boundary ratios
    r = 2 + (xs() % 125);
    apb(1'b1, OFS_OUTCFG + 8'h04, cfg(127, 3, 0));
    apb(1'b1, OFS_OUTCFG + 8'h08, cfg(r, 5, 7));
    apb(1'b1, OFS_OUTCFG + 8'h0c, cfg(2, 0, 0) | (32'h1 << CFG_UNUSED_BIT));
    apb(1'b1, OFS_CTRL, 32'h0);
    per(0, pd, hw);
    chk(pd, 6);
    chk(hw, 3);
    per(1, pd, hw);
    chk(pd, 127);
    chk(hw, 64);
    per(2, pd, hw);
    chk(pd, r);
    chk(hw, (r + 1) / 2);
    chk(pll_clk_out[3], 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[3], 1'b0);
    apb(1'b1, OFS_OUTCFG + 8'h0c, cfg(1, 0, 0));
    repeat (30) @(posedge pclk);
    #1;
    chk(pll_clk_out[3], 1'b1);
    // Fabric stop with and without its enable
    apb(1'b1, OFS_CTRL, 32'h40);
    @(posedge pclk);
    stop_req <= 4'h4;
    repeat (300) @(posedge pclk);
    #1;
    chk(pll_clk_out[2], 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[3:0], 4'hb);
    stop_req <= 4'h0;
    per(2, pd, hw);
    chk(pd, r);
    apb(1'b1, OFS_CTRL, 32'h0);
    stop_req <= 4'h4;
    repeat (300) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[3:0], 4'hf);
    stop_req <= 4'h0;
    // Tap count and per-lane update in time reference mode
    apb(1'b1, OFS_CTRL, 32'hf);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[15:8], 8'd20);
    apb(1'b1, OFS_LANE_UPD, 32'h6);
    repeat (2) @(posedge pclk);
    chk({lane_tap[3], lane_tap[2], lane_tap[1], lane_tap[0]}, 32'h00141400);
    chk(dll_out_x1, 1'b0);
    dll_half <= 8'h18;
    repeat (300) @(posedge pclk);
    apb(1'b1, OFS_LANE_UPD, 32'h1);
    repeat (2) @(posedge pclk);
    chk({lane_tap[1], lane_tap[0]}, 16'h140c);
    // Injection mode: every divide code, then every shift
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFS_CTRL, 32'h10f | (32'(k) << CTRL_DLL_DIV_LSB));
      rise(5, a);
      per(5, pd, hw);
      chk(pd, 48 << k);
      per(4, pd, hw);
      chk(pd, 48);
    end
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFS_CTRL, 32'h10f | (32'(s) << CTRL_DLL_SHIFT_LSB));
      // A shift change may leave one runt; the second rise is clean
      rise(5, a);
      rise(5, a);
      rise(4, b);
      if (s == 0) d0 = b - a;
      chk(d0 - (b - a), s);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
